// file: rtl/bdc_map.svh
`ifndef BDC_MAP_SVH
`define BDC_MAP_SVH

// register byte offsets
`define BDC_SYS 9'h000
`define BDC_PIN 9'h004
`define BDC_STAT 9'h008
`define BDC_EVT 9'h00C
`define BDC_BASE_A 9'h0D0
`define BDC_BASE_B 9'h0E0
`define BDC_OFS_PRI 9'h000
`define BDC_OFS_RET 9'h004
`define BDC_OFS_CEIL 9'h008
`define BDC_OFS_CTRL 9'h00C
`define BDC_LOCK_LO 9'h0D0
`define BDC_LOCK_HI 9'h14F

// field positions
`define BDC_SYS_LOCK 0
`define BDC_SYS_TRIM 8
`define BDC_PIN_GPO 0
`define BDC_PIN_LVL 2
`define BDC_PIN_IN0 4
`define BDC_STAT_PG 0
`define BDC_STAT_RDY 2
`define BDC_STAT_ON 4

// reset values; target code n means 300 mV + n * 10 mV
`define BDC_RST_TRIM 5'h10
`define BDC_RST_TGT 7'h46
`define BDC_RST_CEIL 7'h7F
`define BDC_RST_CTRL 24'h0001A0
`define BDC_VMIN_MV 300
`define BDC_STEP_MV 10

// timing
`define BDC_CLK_MHZ 125
`define BDC_SLEW0_NS 4000
`define BDC_SLEW1_NS 2000
`define BDC_SLEW2_NS 1000
`define BDC_SLEW3_NS 500
`define BDC_OCX_NS 10000
`define BDC_CYC(ns) ((((ns) * `BDC_CLK_MHZ) + 999) / 1000)

`endif

// file: rtl/bdc_pkg.sv
package bdc_pkg;

	typedef enum logic [1:0] {
		BDC_MODE_SEL = 2'b00,
		BDC_MODE_PFM = 2'b01,
		BDC_MODE_PWM = 2'b10,
		BDC_MODE_AUTO = 2'b11
	} bdc_mode_e;

	typedef struct packed {
		logic shutdown_ramp;
		logic [1:0] startup_ramp;
		logic [1:0] hw_select_source;
		logic [1:0] hw_enable_source;
		logic [1:0] ramp_done_route;
		logic [1:0] pg_pin_route;
		logic oc_ramp_mask;
		logic overcurrent_mask;
		logic pg_ramp_mask;
		logic pulldown_off;
		logic [1:0] phase_sel;
		logic shedding_enable;
		bdc_mode_e op_mode;
		logic [1:0] slew;
		logic target_select;
		logic enable;
	} bdc_ctrl_s;

	typedef logic [6:0] bdc_code_t;

endpackage

// file: rtl/bdc_insync.sv
`timescale 1ns/1ps

module bdc_insync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// pins in, settled value out
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} bdc_sync_s;

	bdc_sync_s st_q, st_d;

	always_comb begin
		st_d = st_q;
		st_d.s1 = din;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		// a bit counts only once two later stages agree
		for (int i = 0; i < W; i++) begin
			if (st_q.s2[i] == st_q.s3[i]) begin
				st_d.q[i] = st_q.s3[i];
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign dout = st_q.q;

endmodule

// file: rtl/bdc_ramp.sv
`timescale 1ns/1ps

module bdc_ramp
	import bdc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// control
	input wire logic jump,
	input wire bdc_pkg::bdc_code_t tgt,
	input wire logic [9:0] interval,
	// state
	output bdc_pkg::bdc_code_t cur,
	output logic busy
);

	typedef struct packed {
		bdc_code_t cur;
		logic [9:0] cnt;
	} bdc_ramp_s;

	bdc_ramp_s st_q, st_d;

	always_comb begin
		st_d = st_q;
		if (jump) begin
			st_d.cur = tgt;
			st_d.cnt = '0;
		end else if (st_q.cur != tgt) begin
			if (st_q.cnt >= interval - 10'h001) begin
				st_d.cnt = '0;
				st_d.cur = (st_q.cur < tgt) ? st_q.cur + 7'h01 : st_q.cur - 7'h01;
			end else begin
				st_d.cnt = st_q.cnt + 10'h001;
			end
		end else begin
			st_d.cnt = '0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign cur = st_q.cur;
	assign busy = (st_q.cur != tgt);

endmodule

// file: rtl/bdc_top.sv
// Behaviour
// - targets are 7-bit codes, 300 mV plus 10 mV per code, up to 1.57 V.
// - power-good sets above threshold, clears below threshold minus hysteresis and while the buck is off.
// - a per-buck mask holds power-good steady while that buck ramps.
// - power-good readable in status; routable onto aux pin two or three.
// - host write of a pin level overrides it until routed source next changes.
// - rewriting the selected target or toggling selection starts a ramp.
// - per-buck ready, routable to a pin, reports digital ramp only.
// - slew is one code per 4, 2, 1 or 0.5 us, two-bit field.
// - disabled bucks pull down their selected phases unless disabled; none while off.
// - oscillator trim field is driven out to the oscillator.
// - mode field picks forced PWM, PFM or load-driven automatic.
// - shedding in PWM drops to one phase at light load; phase field caps.
// - while the lock bit is set, writes to 0xD0..0x14F are ignored.
// - after reset each buck uses its primary target unless hardware selects.
// - both ramp causes give a ramp; ready stands for its whole length.
// - with mode 00 the selection also picks PWM (primary) or PFM (retention).
// - applied target is clamped to the per-buck ceiling.
// - each edge on an assigned input sets enable or selection to its level.
// - in tracking mode buck A follows the track code; input zero is ignored.
// - start-up ramp on enable; optional ramped shutdown, else pull-down only.
// - current-limit hit sets a sticky event and interrupt unless masked.
// - optional ramp masking keeps blocking events for a time after ramps.
//
// Our own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`include "bdc_map.svh"

module bdc_top (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// analog and pin inputs, asynchronous
	input wire logic dev_active,
	input wire logic [1:0] pg_above,
	input wire logic [1:0] pg_below,
	input wire logic [1:0] oc_limit,
	input wire logic [1:0] heavy_load,
	input wire logic [2:0] gpi,
	// tracking adc, same clock
	input wire bdc_pkg::bdc_code_t track_code,
	// converter controls
	output logic [1:0] buck_on,
	output bdc_pkg::bdc_code_t vout_code_a,
	output bdc_pkg::bdc_code_t vout_code_b,
	output logic [1:0] pwm_mode,
	output logic [2:0] phases_a,
	output logic [2:0] phases_b,
	output logic [3:0] pulldown_a,
	output logic [3:0] pulldown_b,
	output logic [4:0] oscillator_trim,
	output logic oc_irq,
	// aux pins two and three
	output logic [1:0] aux_pin_o,
	output logic [1:0] aux_pin_oe
);
	import bdc_pkg::*;

	typedef struct packed {
		bdc_ctrl_s [1:0] ctrl;
		logic [1:0][6:0] tp;
		logic [1:0][6:0] tr;
		logic [1:0][6:0] ceil;
		logic [1:0][6:0] tgt;
		logic lock;
		logic [4:0] trim;
		logic [1:0] gpo;
		logic [1:0] pin_lvl;
		logic [1:0] in0_fn;
		logic [1:0] on;
		logic [1:0] starting;
		logic [1:0] pg;
		logic [1:0] pg_ind;
		logic [1:0] ev_oc;
		logic [1:0] oc_prev;
		logic [1:0] busy_prev;
		logic [1:0][10:0] oc_cnt;
		logic [2:0] gpi_prev;
		logic [1:0] src_prev;
		logic [1:0] pwm;
		logic [1:0][2:0] phases;
		logic [1:0][3:0] pd;
		logic irq;
		logic wr_pend;
		logic [8:0] waddr;
		logic [31:0] rdata;
	} bdc_top_s;

	localparam logic [10:0] OCX_CYC = 11'(`BDC_CYC(`BDC_OCX_NS));

	bdc_top_s st_q, st_d;
	logic [11:0] syn;
	logic [1:0] r_jump;
	logic [1:0] r_busy;
	logic [1:0][9:0] r_int;
	bdc_code_t [1:0] r_cur;

	function automatic logic [9:0] slew_cyc(input logic [1:0] sel);
		case (sel)
			2'b00: slew_cyc = 10'(`BDC_CYC(`BDC_SLEW0_NS));
			2'b01: slew_cyc = 10'(`BDC_CYC(`BDC_SLEW1_NS));
			2'b10: slew_cyc = 10'(`BDC_CYC(`BDC_SLEW2_NS));
			default: slew_cyc = 10'(`BDC_CYC(`BDC_SLEW3_NS));
		endcase
	endfunction

	function automatic bdc_code_t clamp(input bdc_code_t v, input bdc_code_t c);
		clamp = (v > c) ? c : v;
	endfunction

	// input source codes: 01 -> input 0, 10 -> input 1, 11 -> input 2
	function automatic logic pick(input logic [1:0] src, input logic [2:0] v);
		pick = (src == 2'b00) ? 1'b0 : v[src - 2'b01];
	endfunction

	function automatic logic [8:0] buck_base(input int b);
		buck_base = (b == 0) ? `BDC_BASE_A : `BDC_BASE_B;
	endfunction

	bdc_insync #(
		.W(12)
	) u_sync (
		.clk(clk),
		.rstn(rstn),
		.din({dev_active, heavy_load, oc_limit, pg_above, pg_below, gpi}),
		.dout(syn)
	);

	for (genvar g = 0; g < 2; g++) begin : g_ramp
		bdc_ramp u_ramp (
			.clk(clk),
			.rstn(rstn),
			.jump(r_jump[g]),
			.tgt(st_q.tgt[g]),
			.interval(r_int[g]),
			.cur(r_cur[g]),
			.busy(r_busy[g])
		);
	end

	always_comb begin
		logic addr_ph;
		logic dev;
		logic [2:0] gv;
		logic [2:0] gedge;
		logic [1:0] above;
		logic [1:0] below;
		logic [1:0] ocl;
		logic [1:0] heavy;
		logic [8:0] ra;
		logic [31:0] rd;
		logic sel;
		logic pwm_eff;
		logic [2:0] cap;
		logic masked;
		bdc_code_t code;
		logic has_pg;
		logic has_rdy;
		logic pg_all;
		logic rdy_any;
		logic src;
		addr_ph = 1'b0;
		dev = 1'b0;
		gv = '0;
		gedge = '0;
		above = '0;
		below = '0;
		ocl = '0;
		heavy = '0;
		ra = '0;
		rd = '0;
		sel = 1'b0;
		pwm_eff = 1'b0;
		cap = '0;
		masked = 1'b0;
		code = '0;
		has_pg = 1'b0;
		has_rdy = 1'b0;
		pg_all = 1'b1;
		rdy_any = 1'b0;
		src = 1'b0;
		r_jump = '0;
		r_int = '0;
		st_d = st_q;

		{dev, heavy, ocl, above, below, gv} = syn;
		gedge = gv ^ st_q.gpi_prev;
		st_d.gpi_prev = gv;
		if (st_q.in0_fn == 2'b01) begin
			gedge[0] = 1'b0;
		end

		// bus address phase: capture write, prepare read data
		addr_ph = hsel & htrans[1] & hready;
		st_d.wr_pend = addr_ph & hwrite;
		st_d.waddr = haddr[8:0];
		ra = haddr[8:0];
		case (ra)
			`BDC_SYS: rd = 32'({st_q.trim, 7'h00, st_q.lock});
			`BDC_PIN: rd = 32'({st_q.in0_fn, st_q.pin_lvl, st_q.gpo});
			`BDC_STAT: rd = 32'({st_q.on, r_busy, st_q.pg_ind});
			`BDC_EVT: rd = 32'(st_q.ev_oc);
			default: rd = '0;
		endcase
		for (int b = 0; b < 2; b++) begin
			if (ra == buck_base(b) + `BDC_OFS_PRI) rd = 32'(st_q.tp[b]);
			if (ra == buck_base(b) + `BDC_OFS_RET) rd = 32'(st_q.tr[b]);
			if (ra == buck_base(b) + `BDC_OFS_CEIL) rd = 32'(st_q.ceil[b]);
			if (ra == buck_base(b) + `BDC_OFS_CTRL) rd = 32'(st_q.ctrl[b]);
		end
		if (addr_ph & ~hwrite) begin
			st_d.rdata = rd;
		end

		// bus data phase: writes, dropped in the locked window
		if (st_q.wr_pend & ~(st_q.lock & st_q.waddr >= `BDC_LOCK_LO
				& st_q.waddr <= `BDC_LOCK_HI)) begin
			case (st_q.waddr)
				`BDC_SYS: begin
					st_d.lock = hwdata[`BDC_SYS_LOCK];
					st_d.trim = hwdata[`BDC_SYS_TRIM +: 5];
				end
				`BDC_PIN: begin
					st_d.gpo = hwdata[`BDC_PIN_GPO +: 2];
					st_d.pin_lvl = hwdata[`BDC_PIN_LVL +: 2];
					st_d.in0_fn = hwdata[`BDC_PIN_IN0 +: 2];
				end
				`BDC_EVT: st_d.ev_oc = st_q.ev_oc & ~hwdata[1:0];
				default: ;
			endcase
			for (int b = 0; b < 2; b++) begin
				if (st_q.waddr == buck_base(b) + `BDC_OFS_PRI) st_d.tp[b] = hwdata[6:0];
				if (st_q.waddr == buck_base(b) + `BDC_OFS_RET) st_d.tr[b] = hwdata[6:0];
				if (st_q.waddr == buck_base(b) + `BDC_OFS_CEIL) st_d.ceil[b] = hwdata[6:0];
				if (st_q.waddr == buck_base(b) + `BDC_OFS_CTRL) st_d.ctrl[b] = hwdata[23:0];
			end
		end

		for (int b = 0; b < 2; b++) begin
			// hardware edges override a same-cycle register write
			if (st_q.ctrl[b].hw_enable_source != 2'b00
					& pick(st_q.ctrl[b].hw_enable_source, gedge)) begin
				st_d.ctrl[b].enable = pick(st_q.ctrl[b].hw_enable_source, gv);
			end
			if (st_q.ctrl[b].hw_select_source != 2'b00
					& pick(st_q.ctrl[b].hw_select_source, gedge)) begin
				st_d.ctrl[b].target_select = pick(st_q.ctrl[b].hw_select_source, gv);
			end

			sel = st_q.ctrl[b].target_select;
			// new code from selection feeds the ramp
			code = clamp(sel ? st_q.tr[b] : st_q.tp[b], st_q.ceil[b]);
			if (b == 0 && st_q.in0_fn == 2'b01) begin
				code = clamp(track_code, st_q.ceil[b]);
			end

			// enable, start-up and shutdown ramps
			st_d.on[b] = dev & (st_q.ctrl[b].enable
				| (st_q.ctrl[b].shutdown_ramp & st_q.on[b] & r_cur[b] != 7'h00));
			st_d.tgt[b] = st_q.ctrl[b].enable ? code : 7'h00;
			st_d.starting[b] = dev & st_q.ctrl[b].enable
				& (~st_q.on[b] | (st_q.starting[b] & r_busy[b]));
			r_jump[b] = ~st_q.on[b]
				| (st_q.starting[b] & st_q.ctrl[b].startup_ramp == 2'b00);
			r_int[b] = st_q.starting[b] ? slew_cyc(st_q.ctrl[b].startup_ramp)
				: slew_cyc(st_q.ctrl[b].slew);

			// power-good with hysteresis, held while masked ramp runs
			if (~st_q.on[b]) begin
				st_d.pg[b] = 1'b0;
			end else if (above[b]) begin
				st_d.pg[b] = 1'b1;
			end else if (below[b]) begin
				st_d.pg[b] = 1'b0;
			end
			if (~(st_q.ctrl[b].pg_ramp_mask & r_busy[b])) begin
				st_d.pg_ind[b] = st_q.pg[b];
			end

			// operating mode and phase count
			case (st_q.ctrl[b].op_mode)
				BDC_MODE_SEL: pwm_eff = ~sel;
				BDC_MODE_PFM: pwm_eff = 1'b0;
				BDC_MODE_PWM: pwm_eff = 1'b1;
				default: pwm_eff = heavy[b];
			endcase
			st_d.pwm[b] = pwm_eff;
			cap = {1'b0, st_q.ctrl[b].phase_sel} + 3'h1;
			st_d.phases[b] = (st_q.ctrl[b].shedding_enable & pwm_eff & ~heavy[b])
				? 3'h1 : cap;

			for (int p = 0; p < 4; p++) begin
				st_d.pd[b][p] = dev & ~st_q.on[b] & ~st_q.ctrl[b].pulldown_off
					& (3'(p) < cap);
			end

			// over-current events with optional post-ramp blanking
			st_d.oc_prev[b] = ocl[b];
			st_d.busy_prev[b] = r_busy[b];
			if (st_q.busy_prev[b] & ~r_busy[b]) begin
				st_d.oc_cnt[b] = OCX_CYC;
			end else if (st_q.oc_cnt[b] != 11'h000) begin
				st_d.oc_cnt[b] = st_q.oc_cnt[b] - 11'h001;
			end
			masked = st_q.ctrl[b].overcurrent_mask | (st_q.ctrl[b].oc_ramp_mask
				& (r_busy[b] | st_q.oc_cnt[b] != 11'h000));
			if (ocl[b] & ~st_q.oc_prev[b] & ~masked) begin
				st_d.ev_oc[b] = 1'b1;
			end
		end
		st_d.irq = |st_d.ev_oc;

		// aux pins: ready routing takes precedence over power-good
		for (int p = 0; p < 2; p++) begin
			has_pg = 1'b0;
			has_rdy = 1'b0;
			pg_all = 1'b1;
			rdy_any = 1'b0;
			for (int b = 0; b < 2; b++) begin
				if (st_q.ctrl[b].pg_pin_route == 2'(p + 1)) begin
					has_pg = 1'b1;
					pg_all = pg_all & st_q.pg_ind[b];
				end
				if (st_q.ctrl[b].ramp_done_route == 2'(p + 1)) begin
					has_rdy = 1'b1;
					rdy_any = rdy_any | r_busy[b];
				end
			end
			src = has_rdy ? rdy_any : pg_all;
			st_d.src_prev[p] = src;
			if ((has_pg | has_rdy) & src != st_q.src_prev[p]) begin
				st_d.pin_lvl[p] = src;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= '0;
			st_q.ctrl <= {2{`BDC_RST_CTRL}};
			st_q.tp <= {2{`BDC_RST_TGT}};
			st_q.tr <= {2{`BDC_RST_TGT}};
			st_q.ceil <= {2{`BDC_RST_CEIL}};
			st_q.trim <= `BDC_RST_TRIM;
		end else begin
			st_q <= st_d;
		end
	end

	assign hrdata = st_q.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign buck_on = st_q.on;
	assign vout_code_a = r_cur[0];
	assign vout_code_b = r_cur[1];
	assign pwm_mode = st_q.pwm;
	assign phases_a = st_q.phases[0];
	assign phases_b = st_q.phases[1];
	assign pulldown_a = st_q.pd[0];
	assign pulldown_b = st_q.pd[1];
	assign oscillator_trim = st_q.trim;
	assign oc_irq = st_q.irq;
	assign aux_pin_o = st_q.pin_lvl;
	assign aux_pin_oe = st_q.gpo;

endmodule

// file: test/bdc_top_properties.sv
`timescale 1ns/1ps

module bdc_top_checker (
	// clock, reset and bus
	input wire logic clk,
	input wire logic rstn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	// pins and converter side
	input wire logic dev_active,
	input wire logic [1:0] oc_limit,
	input wire logic [1:0] buck_on,
	input wire bdc_pkg::bdc_code_t vout_code_a,
	input wire logic [3:0] pulldown_a,
	input wire logic [3:0] pulldown_b,
	input wire logic [4:0] oscillator_trim,
	input wire logic oc_irq
);
	logic sys_wr;

	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	// address phase of a write to the system register
	assign sys_wr = hsel & htrans[1] & hready & hwrite & (haddr[8:0] == 9'h000);

	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("bus answer not ready and okay");
	trim_reset_a: assert property ($rose(rstn) |-> oscillator_trim == 5'h10)
		else $error("trim not at reset value");
	trim_write_a: assert property ($changed(oscillator_trim) |-> $past(sys_wr, 2) || $past(sys_wr, 3))
		else $error("trim moved without a write");
	code_hold_a: assert property ($changed(vout_code_a) && buck_on[0] && $past(buck_on[0])
		|=> $stable(vout_code_a)[*8])
		else $error("ramp steps too close together");
	pd_dev_off_a: assert property ((!dev_active)[*6] |-> pulldown_a == 4'h0 && pulldown_b == 4'h0)
		else $error("pull-down active while device off");
	pd_running_a: assert property (buck_on[0] && $past(buck_on[0]) |-> pulldown_a == 4'h0)
		else $error("pull-down active on running buck");
	off_idle_a: assert property ((!dev_active)[*8] |-> buck_on == 2'b00)
		else $error("buck running while device off");
	// the event needs sync stages and an edge detect before the irq flop
	oc_cause_a: assert property ($rose(oc_irq) |-> $past(|oc_limit, 4) || $past(|oc_limit, 5)
		|| $past(|oc_limit, 6) || $past(|oc_limit, 7))
		else $error("irq without current limit");
endmodule

bind bdc_top bdc_top_checker i_bdc_top_checker (.clk(clk), .rstn(rstn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .dev_active(dev_active), .oc_limit(oc_limit), .buck_on(buck_on),
	.vout_code_a(vout_code_a), .pulldown_a(pulldown_a), .pulldown_b(pulldown_b),
	.oscillator_trim(oscillator_trim), .oc_irq(oc_irq));

// file: test/bdc_plant.sv
`timescale 1ns/1ps

module bdc_plant (
	// clock
	input wire logic clk,
	// converter side
	input wire logic [1:0] buck_on,
	input wire logic [1:0] oc_cmd,
	output logic [1:0] pg_above,
	output logic [1:0] pg_below,
	output logic [1:0] oc_limit,
	output logic [1:0] heavy_load
);
	logic [4:0] cnt_q [2] = '{5'h00, 5'h00};

	// output settles some time after the buck starts, collapses at once when off
	always @(posedge clk) begin
		for (int i = 0; i < 2; i++) begin
			cnt_q[i] <= !buck_on[i] ? 5'h00 : (cnt_q[i] == 5'h10 ? cnt_q[i] : cnt_q[i] + 5'h01);
		end
	end

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			// gap between the two levels stands in for hysteresis
			pg_above[i] = cnt_q[i] == 5'h10;
			pg_below[i] = cnt_q[i] < 5'h08;
			heavy_load[i] = cnt_q[i][4];
		end
		oc_limit = oc_cmd;
	end
endmodule

// file: test/test_buck_dvc_control.sv
`timescale 1ns/1ps

module test_buck_dvc_control;
	import bdc_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic dev_active = 1'b1;
	logic rd_dp = 1'b0;
	logic pr = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, last, span, pr_got;
	logic [1:0] htrans = 2'b00, oc_cmd = 2'b00, pg_above, pg_below, oc_limit, heavy_load;
	logic [1:0] buck_on, pwm_mode, aux_pin_o, aux_pin_oe;
	logic [2:0] hsize = 3'b010, gpi = 3'b000, phases_a, phases_b, pr_sel = 3'h0;
	logic [3:0] pulldown_a, pulldown_b;
	logic [4:0] oscillator_trim, trim;
	logic hreadyout, hresp, oc_irq;
	bdc_code_t track_code = 7'h40, vout_code_a, vout_code_b, tgt, v;
	logic [31:0] q [$];
	logic [8:0] rst_addr [6] = '{9'h0D0, 9'h0D4, 9'h0D8, 9'h0DC, 9'h000, 9'h010};
	logic [31:0] rst_val [6] = '{32'h46, 32'h46, 32'h7F, 32'h1A0, 32'h1000, 32'h0};
	int error_cnt = 0, tests_run = 0, cyc = 0;

	always #4 clk = ~clk;

	bdc_top i_bdc_top (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .dev_active(dev_active), .pg_above(pg_above),
		.pg_below(pg_below), .oc_limit(oc_limit), .heavy_load(heavy_load), .gpi(gpi),
		.track_code(track_code), .buck_on(buck_on), .vout_code_a(vout_code_a),
		.vout_code_b(vout_code_b), .pwm_mode(pwm_mode), .phases_a(phases_a),
		.phases_b(phases_b), .pulldown_a(pulldown_a), .pulldown_b(pulldown_b),
		.oscillator_trim(oscillator_trim), .oc_irq(oc_irq), .aux_pin_o(aux_pin_o),
		.aux_pin_oe(aux_pin_oe));

	bdc_plant i_bdc_plant (.clk(clk), .buck_on(buck_on), .oc_cmd(oc_cmd), .pg_above(pg_above),
		.pg_below(pg_below), .oc_limit(oc_limit), .heavy_load(heavy_load));

	always_comb begin
		case (pr_sel)
			3'h0: pr_got = {25'h0, vout_code_a};
			3'h1: pr_got = {27'h0, oscillator_trim};
			3'h2: pr_got = {31'h0, pwm_mode[0]};
			3'h3: pr_got = {31'h0, aux_pin_o[0]};
			3'h4: pr_got = {28'h0, pulldown_a};
			3'h5: pr_got = {31'h0, oc_irq};
			3'h6: pr_got = span;
			default: pr_got = {30'h0, buck_on};
		endcase
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// result watcher: oldest note against read data or probed pin
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (rd_dp === 1'b1 || pr === 1'b1) begin
			tests_run++;
			if ((rd_dp === 1'b1 ? hrdata : pr_got) !== q[0]) begin
				error_cnt++;
				$display("MISMATCH at %0t: expected %h got %h", $time, q[0],
					rd_dp === 1'b1 ? hrdata : pr_got);
			end
			void'(q.pop_front());
		end
		if (cyc == 40000) begin
			error_cnt++;
			stop_test();
		end
	end

	task automatic xfer(input logic w, input logic [8:0] a, input logic [31:0] d, input logic c,
		input logic [31:0] e);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {23'h0, a};
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		rd_dp <= c;
		if (c) q.push_back(e);
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd_dp <= 1'b0;
		last = hrdata;
	endtask

	task automatic wr(input logic [8:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, 1'b0, 32'h0);
	endtask

	task automatic rd(input logic [8:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0, 1'b1, e);
	endtask

	// registered outputs settle a few edges after the cause
	task automatic probe(input logic [2:0] s, input logic [31:0] e);
		repeat (3) @(posedge clk);
		q.push_back(e);
		pr_sel <= s;
		pr <= 1'b1;
		@(posedge clk);
		pr <= 1'b0;
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		repeat (4) @(posedge clk);
		do begin
			xfer(1'b0, 9'h008, 32'h0, 1'b0, 32'h0);
			n++;
		end while (last[3:2] !== 2'b00 && n < 3000);
	endtask

	task automatic edge_wait();
		int n;
		n = 0;
		v = vout_code_a;
		while (vout_code_a === v && n < 300) begin
			@(posedge clk);
			n++;
		end
		span = n;
	endtask

	initial begin
		void'($urandom(84));
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		foreach (rst_addr[i]) rd(rst_addr[i], rst_val[i]);
		$display("reset values done");
		trim = 5'($urandom());
		wr(9'h000, {19'h0, trim, 8'h00});
		probe(3'h1, {27'h0, trim});
		$display("trim done");
		wr(9'h0DC, 32'h1AD);
		wait_idle();
		probe(3'h0, 32'h46);
		tgt = 7'h49 + 7'($urandom_range(7));
		wr(9'h0D8, 32'h4C);
		wr(9'h0D0, {25'h0, tgt});
		edge_wait();
		edge_wait();
		probe(3'h6, 32'd63);
		rd(9'h008, 32'h15);
		wait_idle();
		probe(3'h0, {25'h0, tgt < 7'h4C ? tgt : 7'h4C});
		$display("ramp done");
		wr(9'h0D4, 32'h44);
		wr(9'h0DC, 32'h18F);
		probe(3'h2, 32'h0);
		wait_idle();
		probe(3'h0, 32'h44);
		wr(9'h0DC, 32'h18D);
		probe(3'h2, 32'h1);
		wait_idle();
		$display("select done");
		wr(9'h000, {19'h0, trim, 8'h01});
		wr(9'h0D0, 32'h20);
		rd(9'h0D0, {25'h0, tgt});
		wr(9'h000, {19'h0, trim, 8'h00});
		rd(9'h000, {19'h0, trim, 8'h00});
		$display("lock done");
		wr(9'h004, 32'h1);
		wr(9'h0DC, 32'h218D);
		probe(3'h3, 32'h0);
		wr(9'h0DC, 32'h2180);
		repeat (40) @(posedge clk);
		probe(3'h4, 32'hF);
		rd(9'h008, 32'h0);
		wr(9'h0DC, 32'h218D);
		repeat (40) @(posedge clk);
		probe(3'h3, 32'h1);
		$display("power good done");
		for (int m = 0; m < 2; m++) begin
			wr(9'h0DC, m ? 32'h298D : 32'h218D);
			oc_cmd <= 2'b01;
			repeat (20) @(posedge clk);
			oc_cmd <= 2'b00;
			rd(9'h00C, m ? 32'h0 : 32'h1);
			probe(3'h5, m ? 32'h0 : 32'h1);
			wr(9'h00C, 32'h3);
		end
		rd(9'h00C, 32'h0);
		$display("over-current done");
		wr(9'h0EC, 32'h2018C);
		gpi <= 3'b001;
		repeat (10) @(posedge clk);
		probe(3'h7, 32'h3);
		gpi <= 3'b000;
		repeat (10) @(posedge clk);
		probe(3'h7, 32'h1);
		$display("hardware enable done");
		dev_active <= 1'b0;
		repeat (20) @(posedge clk);
		probe(3'h4, 32'h0);
		$display("device off done");
		stop_test();
	end
endmodule
